// File: core/dcs_pkg.sv
// Shared constants for the loop control, status and serial pin block
package dcs_pkg;

   // Register offsets on the serial port
   localparam logic [7:0] OFS_MODE_SELECT = 8'h1f;
   localparam logic [7:0] OFS_CONTROL     = 8'h20;
   localparam logic [7:0] OFS_STATUS      = 8'h21;

   // Control register fields
   localparam int CTL_HS_VALUE    = 0;
   localparam int CTL_HS_OVERRIDE = 1;
   localparam int CTL_SL_VALUE    = 2;
   localparam int CTL_SL_OVERRIDE = 3;

   // Reset values
   localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
   localparam logic [3:0] CONTROL_RESET     = 4'h0;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   // Synchroniser lanes; pulled-up pins reset to one
   localparam int SYN_WIDTH = 11;
   localparam int SYN_HS    = 0;
   localparam int SYN_MODE0 = 1;
   localparam int SYN_MODE1 = 2;
   localparam int SYN_ROLE  = 3;
   localparam int SYN_D0    = 4;
   localparam int SYN_D1    = 5;
   localparam int SYN_PORT  = 6;
   localparam int SYN_SEL   = 7;
   localparam int SYN_CLK   = 8;
   localparam int SYN_DATA  = 9;
   localparam int SYN_SPARE = 10;
   localparam logic [SYN_WIDTH-1:0] SYN_RESET = 11'h7ff;

   // Enabled cycles after reset before the mode pins are taken
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

   // Four-wire frame: command byte then data byte
   localparam logic [4:0] SPI_CMD_BITS   = 5'h08;
   localparam logic [4:0] SPI_FRAME_BITS = 5'h10;

   // Two-wire device address, upper six bits (arbitrary value)
   localparam logic [5:0] TWI_ADDR_HIGH = 6'h2a;

   // Default loop modes, in pin-level order
   typedef enum logic [1:0] {
      MODE_AUTOMATIC,
      MODE_NORMAL,
      MODE_HOLDOVER,
      MODE_FREERUN
   } dcs_mode_t;

endpackage : dcs_pkg

// File: core/dcs_sync2.sv
// Two-flop synchroniser for pins from outside the core clock domain
`timescale 1ns/1ps
`default_nettype none
module dcs_sync2 #(
   parameter int                WIDTH     = 1,
   parameter logic [WIDTH-1:0]  RESET_VAL = '1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // Pins and synchronised levels
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinSync
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } dcs_sync_t;

   dcs_sync_t state;
   dcs_sync_t next_state;

   always_comb begin
      next_state = state;
      if (ce) begin
         next_state.meta   = pinIn;
         next_state.stable = state.meta;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{meta: RESET_VAL, stable: RESET_VAL};
      end else begin
         state <= next_state;
      end
   end

   assign pinSync = state.stable;

endmodule : dcs_sync2
`default_nettype wire

// File: core/dcs_twi_target.sv
// Two-wire target: address match, register pointer, byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module dcs_twi_target
   import dcs_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Synchronised line levels
   input  wire logic       enable,
   input  wire logic       sclLevel,
   input  wire logic       sdaLevel,
   input  wire logic       addrBitZero,
   // Register access
   input  wire logic [7:0] readData,
   output logic      [7:0] regPtr,
   output logic      [7:0] writeData,
   output logic            writeStrobe,
   // Data line pull-down, low while pulling
   output logic            sdaOeN
);

   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} dcs_twi_st_t;

   typedef struct packed {
      dcs_twi_st_t st;
      logic        sclPrev;
      logic        sdaPrev;
      logic [2:0]  bitCnt;
      logic [7:0]  shift;
      logic        byteDone;
      logic        addrPhase;
      logic        gotPtr;
      logic        readDir;
      logic        nack;
      logic [7:0]  ptr;
      logic [7:0]  wData;
      logic        wStb;
      logic        sdaOeN;
   } dcs_twi_t;

   dcs_twi_t state;
   dcs_twi_t next_state;
   logic     sclRise;
   logic     sclFall;

   always_comb begin
      next_state = state;
      sclRise = 1'b0;
      sclFall = 1'b0;
      if (ce) begin
         next_state.wStb    = 1'b0;
         next_state.sclPrev = sclLevel;
         next_state.sdaPrev = sdaLevel;
         sclRise = sclLevel & ~state.sclPrev;
         sclFall = ~sclLevel & state.sclPrev;
         if (!enable || (sclLevel && state.sclPrev && sdaLevel && !state.sdaPrev)) begin
            // Stop, or port not selected
            next_state.st     = ST_IDLE;
            next_state.sdaOeN = 1'b1;
         end else if (sclLevel && state.sclPrev && !sdaLevel && state.sdaPrev) begin
            // Start or repeated start
            next_state.st        = ST_RX;
            next_state.bitCnt    = 3'h0;
            next_state.byteDone  = 1'b0;
            next_state.addrPhase = 1'b1;
            next_state.gotPtr    = 1'b0;
            next_state.sdaOeN    = 1'b1;
         end else begin
            unique case (state.st)
               ST_IDLE: ;
               ST_RX: begin
                  if (sclRise) begin
                     next_state.shift    = {state.shift[6:0], sdaLevel};
                     next_state.bitCnt   = state.bitCnt + 3'h1;
                     next_state.byteDone = (state.bitCnt == 3'h7);
                  end else if (sclFall && state.byteDone) begin
                     next_state.byteDone = 1'b0;
                     next_state.st       = ST_ACK;
                     next_state.sdaOeN   = 1'b0;
                     if (state.addrPhase) begin
                        // select pin is address bit 0
                        if (state.shift[7:1] == {TWI_ADDR_HIGH, addrBitZero}) begin
                           next_state.addrPhase = 1'b0;
                           next_state.readDir   = state.shift[0];
                        end else begin
                           next_state.st     = ST_IDLE;
                           next_state.sdaOeN = 1'b1;
                        end
                     end else if (!state.gotPtr) begin
                        next_state.ptr    = state.shift;
                        next_state.gotPtr = 1'b1;
                     end else begin
                        next_state.wData = state.shift;
                        next_state.wStb  = 1'b1;
                     end
                  end
               end
               ST_ACK: begin
                  if (sclFall) begin
                     next_state.bitCnt = 3'h0;
                     if (state.readDir) begin
                        next_state.st     = ST_TX;
                        next_state.shift  = readData;
                        next_state.sdaOeN = readData[7];
                     end else begin
                        next_state.st     = ST_RX;
                        next_state.sdaOeN = 1'b1;
                     end
                  end
               end
               ST_TX: begin
                  if (sclFall) begin
                     next_state.bitCnt = state.bitCnt + 3'h1;
                     if (state.bitCnt == 3'h7) begin
                        next_state.st     = ST_TXACK;
                        next_state.sdaOeN = 1'b1;
                     end else begin
                        next_state.shift  = {state.shift[6:0], 1'b0};
                        next_state.sdaOeN = state.shift[6];
                     end
                  end
               end
               ST_TXACK: begin
                  if (sclRise) begin
                     next_state.nack = sdaLevel;
                  end else if (sclFall) begin
                     next_state.bitCnt = 3'h0;
                     next_state.st     = state.nack ? ST_IDLE : ST_TX;
                     next_state.shift  = readData;
                     next_state.sdaOeN = state.nack | readData[7];
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{st: ST_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, sdaOeN: 1'b1, default: '0};
      end else begin
         state <= next_state;
      end
   end

   assign regPtr      = state.ptr;
   assign writeData   = state.wData;
   assign writeStrobe = state.wStb;
   assign sdaOeN      = state.sdaOeN;

endmodule : dcs_twi_target
`default_nettype wire

// File: core/dcs_pins.sv
// Control straps, loop status pins and shared four-wire / two-wire serial port
//
// How it works
// - Hitless strap high enables hitless reference switching.
// - Hitless strap low disables it and pulses an output phase realign.
// - Mode pins taken just after reset give the default loop mode.
// - Later, mode follows pin changes or a write to register 0x1F.
// - Role pin high selects slave; a control register can override role.
// - Role pin low selects master.
// - Output zero enable high turns on differential driver zero.
// - Output one enable high turns on differential driver one.
// - An enable low turns its driver off to save power.
// - Lock output high only while frequency and phase both locked.
// - Holdover output high while the loop is in holdover.
// - Port strap 0 gives four-wire clock, 1 gives two-wire clock line.
// - Port strap low gives four-wire data in, high two-wire data line.
// - Serial output pin used only in four-wire mode, released otherwise.
// - Four-wire mode: select pin is active-low chip select from host.
// - Two-wire mode: select pin level is device address bit zero.
// - Undriven pulled-up inputs read high from reset onward.
// - Port strap high enables two-wire port, low the four-wire port.
// - Reset clears the device; board must reset after power-up.
`timescale 1ns/1ps
`default_nettype none
module dcs_pins
   import dcs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       ce,
   // Strap and control pins
   input  wire logic       hitlessSwitchStrap,
   input  wire logic       primaryLoopModeBitLow,
   input  wire logic       primaryLoopModeBitHigh,
   input  wire logic       roleSelectPin,
   input  wire logic       differentialOutZeroEnable,
   input  wire logic       differentialOutOneEnable,
   input  wire logic       twoWirePortStrap,
   // Loop status from the loop core
   input  wire logic       loopFreqLocked,
   input  wire logic       loopPhaseLocked,
   input  wire logic       loopInHoldover,
   // Shared serial pins
   input  wire logic       sharedClkIn,
   output logic            sharedClkOut,
   output logic            sharedClkOeN,
   input  wire logic       sharedDataIn,
   output logic            sharedDataOut,
   output logic            sharedDataOeN,
   input  wire logic       sharedSelectPin,
   output logic            serialOut,
   output logic            serialOutOeN,
   // Loop control outputs
   output logic            hitlessSwitchEnabled,
   output logic            phaseRealign,
   output logic [1:0]      primaryLoopMode,
   output logic            slaveMode,
   output logic            diffZeroDriverOn,
   output logic            diffOneDriverOn,
   // Status pins
   output logic            primaryLoopLocked,
   output logic            primaryLoopInHoldover,
   output logic            twoWireAddressBitZero
);

   typedef struct packed {
      logic [7:0] dpllPrimaryModeSelect;
      logic [3:0] control;
      logic [1:0] settle;
      logic       captured;
      logic [1:0] modePinsPrev;
      logic       sckPrev;
      logic [4:0] spiCnt;
      logic [7:0] spiShift;
      logic [7:0] spiCmd;
      logic [7:0] spiTx;
      logic       so;
      logic       soOeN;
      logic       hsEn;
      logic       realign;
      logic       slave;
      logic       d0;
      logic       d1;
      logic       lock;
      logic       hold;
      logic       addrBit0;
      logic       sdaOeN;
   } dcs_top_t;

   dcs_top_t              state;
   dcs_top_t              next_state;
   logic [SYN_WIDTH-1:0]  pinRaw;
   logic [SYN_WIDTH-1:0]  pinSync;
   logic [7:0]            twiPtr;
   logic [7:0]            twiWData;
   logic                  twiWStb;
   logic                  twiSdaOeN;
   logic                  twoWire;
   logic                  csActive;
   logic                  sckRise;
   logic                  sckFall;
   logic                  wrStb;
   logic [7:0]            wrAddr;
   logic [7:0]            wrData;
   logic [7:0]            spiByte;

   // Register read decode shared by both ports
   function automatic logic [7:0] regRead(input logic [7:0] addr, input dcs_top_t s, input logic port);
      logic [7:0] v;
      v = UNMAPPED_READ;
      unique case (addr)
         OFS_MODE_SELECT: v = s.dpllPrimaryModeSelect;
         OFS_CONTROL:     v = {4'h0, s.control};
         OFS_STATUS:      v = {port, s.d1, s.d0, s.slave, s.hsEn, s.hold, s.lock, s.captured};
         default:         v = UNMAPPED_READ;
      endcase
      return v;
   endfunction : regRead

   assign pinRaw = {1'b1, sharedDataIn, sharedClkIn, sharedSelectPin, twoWirePortStrap,
                    differentialOutOneEnable, differentialOutZeroEnable, roleSelectPin,
                    primaryLoopModeBitHigh, primaryLoopModeBitLow, hitlessSwitchStrap};

   dcs_sync2 #(
      .WIDTH     (SYN_WIDTH),
      .RESET_VAL (SYN_RESET)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .pinIn    (pinRaw),
      .pinSync  (pinSync)
   );

   // port strap picks the two-wire engine
   assign twoWire = pinSync[SYN_PORT];

   // shared clock line as two-wire clock
   dcs_twi_target u_twi (
      .core_clk    (core_clk),
      .rst         (rst),
      .ce          (ce),
      .enable      (twoWire),
      .sclLevel    (pinSync[SYN_CLK]),
      .sdaLevel    (pinSync[SYN_DATA]),
      .addrBitZero (state.addrBit0),
      .readData    (regRead(twiPtr, state, twoWire)),
      .regPtr      (twiPtr),
      .writeData   (twiWData),
      .writeStrobe (twiWStb),
      .sdaOeN      (twiSdaOeN)
   );

   // chip select active low in four-wire mode
   assign csActive = ~twoWire & ~pinSync[SYN_SEL];
   assign sckRise  = pinSync[SYN_CLK] & ~state.sckPrev;
   assign sckFall  = ~pinSync[SYN_CLK] & state.sckPrev;
   assign spiByte  = {state.spiShift[6:0], pinSync[SYN_DATA]};

   // Write port shared by both engines; four-wire takes the data byte
   always_comb begin
      wrStb  = 1'b0;
      wrAddr = state.spiCmd;
      wrData = spiByte;
      if (twoWire) begin
         wrStb  = twiWStb;
         wrAddr = twiPtr;
         wrData = twiWData;
      end else if (csActive && sckRise && state.spiCnt == SPI_FRAME_BITS - 5'h01 && !state.spiCmd[7]) begin
         wrStb  = 1'b1;
         wrAddr = {1'b0, state.spiCmd[6:0]};
      end
   end

   always_comb begin
      next_state = state;
      if (ce) begin
         next_state.sckPrev = pinSync[SYN_CLK];

         // mode pins caught once the synchroniser has settled
         if (!state.captured) begin
            next_state.settle = state.settle + 2'h1;
            if (state.settle == STRAP_SETTLE_CYCLES - 2'h1) begin
               next_state.captured                   = 1'b1;
               next_state.dpllPrimaryModeSelect[1:0] = {pinSync[SYN_MODE1], pinSync[SYN_MODE0]};
            end
         end
         next_state.modePinsPrev = {pinSync[SYN_MODE1], pinSync[SYN_MODE0]};

         // pin change or register write; the write wins a tie
         if (state.captured && next_state.modePinsPrev != state.modePinsPrev) begin
            next_state.dpllPrimaryModeSelect[1:0] = next_state.modePinsPrev;
         end
         if (wrStb && wrAddr == OFS_MODE_SELECT) begin
            next_state.dpllPrimaryModeSelect = wrData;
         end
         if (wrStb && wrAddr == OFS_CONTROL) begin
            next_state.control = wrData[3:0];
         end

         // hitless from strap unless software overrides
         next_state.hsEn = state.control[CTL_HS_OVERRIDE] ? state.control[CTL_HS_VALUE] : pinSync[SYN_HS];
         // realign pulse when hitless switching turns off
         next_state.realign = state.hsEn & ~next_state.hsEn;
         // high is slave; low is master
         next_state.slave = state.control[CTL_SL_OVERRIDE] ? state.control[CTL_SL_VALUE] : pinSync[SYN_ROLE];
         // driver zero, driver one, off when low
         next_state.d0 = pinSync[SYN_D0];
         next_state.d1 = pinSync[SYN_D1];
         next_state.lock = loopFreqLocked & loopPhaseLocked;
         next_state.hold = loopInHoldover;
         next_state.addrBit0 = pinSync[SYN_SEL];
         // data line pulled low only in two-wire mode
         next_state.sdaOeN = ~twoWire | twiSdaOeN;

         // Four-wire engine: sample on rising, shift out on falling edge
         if (!csActive) begin
            next_state.spiCnt = 5'h00;
            next_state.soOeN  = 1'b1;
            next_state.so     = 1'b0;
         end else begin
            // serial out driven only while selected in four-wire mode
            next_state.soOeN = 1'b0;
            if (sckRise && state.spiCnt != SPI_FRAME_BITS) begin
               next_state.spiShift = spiByte;
               next_state.spiCnt   = state.spiCnt + 5'h01;
               if (state.spiCnt == SPI_CMD_BITS - 5'h01) begin
                  next_state.spiCmd = spiByte;
                  next_state.spiTx  = regRead({1'b0, spiByte[6:0]}, state, twoWire);
               end
            end else if (sckFall && state.spiCmd[7] && state.spiCnt >= SPI_CMD_BITS
                         && state.spiCnt != SPI_FRAME_BITS) begin
               next_state.so    = state.spiTx[7];
               next_state.spiTx = {state.spiTx[6:0], 1'b0};
            end
         end
      end
   end

   // reset brings every control flop to its default
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= '{dpllPrimaryModeSelect: MODE_SELECT_RESET, control: CONTROL_RESET,
                    modePinsPrev: 2'h3, sckPrev: 1'b1, soOeN: 1'b1, hsEn: 1'b1, slave: 1'b1,
                    d0: 1'b1, d1: 1'b1, addrBit0: 1'b1, sdaOeN: 1'b1, default: '0};
      end else begin
         state <= next_state;
      end
   end

   // Clock line is never stretched, so its driver stays released
   assign sharedClkOut          = 1'b0;
   assign sharedClkOeN          = state.sckPrev | 1'b1;
   assign sharedDataOut         = 1'b0;
   assign sharedDataOeN         = state.sdaOeN;
   assign serialOut             = state.so;
   assign serialOutOeN          = state.soOeN;
   assign hitlessSwitchEnabled  = state.hsEn;
   assign phaseRealign          = state.realign;
   assign primaryLoopMode       = state.dpllPrimaryModeSelect[1:0];
   assign slaveMode             = state.slave;
   assign diffZeroDriverOn      = state.d0;
   assign diffOneDriverOn       = state.d1;
   assign primaryLoopLocked     = state.lock;
   assign primaryLoopInHoldover = state.hold;
   assign twoWireAddressBitZero = state.addrBit0;

endmodule : dcs_pins
`default_nettype wire

// File: dv/dcs_pins_monitor.sv
// Concurrent checks on the strap, status and serial pin block
`timescale 1ns/1ps
`default_nettype none
module dcs_pins_monitor
   import dcs_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins and loop status
   input wire logic hitlessSwitchStrap,
   input wire logic roleSelectPin,
   input wire logic differentialOutZeroEnable,
   input wire logic differentialOutOneEnable,
   input wire logic twoWirePortStrap,
   input wire logic sharedSelectPin,
   input wire logic loopFreqLocked,
   input wire logic loopPhaseLocked,
   input wire logic loopInHoldover,
   // Outputs
   input wire logic serialOutOeN,
   input wire logic hitlessSwitchEnabled,
   input wire logic phaseRealign,
   input wire logic slaveMode,
   input wire logic diffZeroDriverOn,
   input wire logic diffOneDriverOn,
   input wire logic primaryLoopLocked,
   input wire logic primaryLoopInHoldover
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Four samples cover the synchroniser plus output flop
   sequence s_high(sig); sig [*4]; endsequence
   sequence s_low(sig); !sig [*4]; endsequence
   property p_follow(pin, out);
      (s_high(pin) |-> out) and (s_low(pin) |-> !out);
   endproperty
   a_hitless_follows_pin: assert property (p_follow(hitlessSwitchStrap, hitlessSwitchEnabled))
      else $error("hitless enable not following pin");
   a_role_follows_pin: assert property (p_follow(roleSelectPin, slaveMode))
      else $error("role not following pin");
   a_diff_zero_driver: assert property (p_follow(differentialOutZeroEnable, diffZeroDriverOn))
      else $error("driver zero not following enable");
   a_diff_one_driver: assert property (p_follow(differentialOutOneEnable, diffOneDriverOn))
      else $error("driver one not following enable");
   a_realign_on_fall: assert property (phaseRealign == $fell(hitlessSwitchEnabled))
      else $error("realign pulse not tied to hitless fall");
   a_lock_needs_both: assert property (!$past(rst) |-> primaryLoopLocked == $past(loopFreqLocked && loopPhaseLocked))
      else $error("lock output wrong");
   a_holdover_tracks: assert property (!$past(rst) |-> primaryLoopInHoldover == $past(loopInHoldover))
      else $error("holdover output wrong");
   a_so_released_twowire: assert property (s_high(twoWirePortStrap) |-> serialOutOeN)
      else $error("serial output driven in two-wire mode");
   a_so_driven_selected: assert property ((!twoWirePortStrap && !sharedSelectPin) [*4] |-> !serialOutOeN)
      else $error("serial output released while selected");
endmodule : dcs_pins_monitor
bind dcs_pins dcs_pins_monitor i_dcs_pins_monitor (.*);
`default_nettype wire

// File: dv/dcs_host_model.sv
// Host-side four-wire and two-wire master on the shared serial pins
`timescale 1ns/1ps
`default_nettype none
module dcs_host_model
   import dcs_pkg::*;
(
   // Core clock paces the link clock
   input  wire logic core_clk,
   // Shared pins
   input  wire logic so,
   output logic      sck,
   output logic      si,
   output logic      csN
);
   initial begin
      sck = 1'b0;
      si  = 1'b0;
      csN = 1'b1;
   end
   // Half of the 160 ns link period
   task automatic half();
      repeat (8) @(posedge core_clk);
      #1;
   endtask : half
   // select held low for one whole frame
   task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
      half();
      csN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         si = tx[i];
         half();
         sck = 1'b1;
         rx  = {rx[6:0], so};
         half();
         sck = 1'b0;
      end
      half();
      csN = 1'b1;
      // Released line must not keep its last value
      si = ~si;
   endtask : xfer
   // two-wire frame, start to stop; last bit low
   task automatic twiFrame(input logic [27:0] bits);
      half();
      si  = 1'b1;
      sck = 1'b1;
      half();
      si = 1'b0;
      for (int i = 27; i >= 0; i--) begin
         half();
         sck = 1'b0;
         half();
         si = bits[i];
         half();
         sck = 1'b1;
      end
      half();
      si = 1'b1;
   endtask : twiFrame
endmodule : dcs_host_model
`default_nettype wire

// File: dv/dcs_pins_bench.sv
// Self-checking bench for the strap, status and serial pin block
`timescale 1ns/1ps
`default_nettype none
module dcs_pins_bench
   import dcs_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hitlessSwitchStrap, primaryLoopModeBitLow, primaryLoopModeBitHigh, roleSelectPin, selPull;
   logic differentialOutZeroEnable, differentialOutOneEnable, twoWirePortStrap;
   logic loopFreqLocked, loopPhaseLocked, loopInHoldover;
   logic sharedClkOut, sharedClkOeN, sharedDataOut, sharedDataOeN, serialOut, serialOutOeN;
   logic hitlessSwitchEnabled, phaseRealign, slaveMode, diffZeroDriverOn, diffOneDriverOn;
   logic primaryLoopLocked, primaryLoopInHoldover, twoWireAddressBitZero;
   logic [1:0] primaryLoopMode;
   logic [7:0] rx;
   logic [7:0] wrModel[$];
   logic [15:0] lfsr = 16'hc84d;
   wire logic sharedClkIn, sharedDataIn, sharedSelectPin, hostSi, hostCsN;
   int n_mismatch = 0;
   int n_tests = 0;
   int nPulse = 0;
   int expPulse = 0;
   // Open-drain data line with pull-up
   assign sharedDataIn    = sharedDataOeN ? hostSi : 1'b0;
   assign sharedSelectPin = hostCsN & selPull;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) if (phaseRealign === 1'b1) nPulse++;
   dcs_pins i_dcs_pins (.*);
   dcs_host_model i_dcs_host_model (.core_clk, .so(serialOut), .sck(sharedClkIn), .si(hostSi), .csN(hostCsN));
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic end_sim();
      $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      {hitlessSwitchStrap, roleSelectPin, differentialOutZeroEnable, differentialOutOneEnable} = 4'hf;
      {primaryLoopModeBitHigh, primaryLoopModeBitLow} = MODE_HOLDOVER;
      {twoWirePortStrap, loopFreqLocked, loopPhaseLocked, loopInHoldover, selPull} = 5'h01;
      cyc(6);
      rst = 1'b0;
      cyc(6);
      chk("default mode", MODE_HOLDOVER, primaryLoopMode);
      chk("hitless", 1'b1, hitlessSwitchEnabled);
      chk("slave", 1'b1, slaveMode);
      for (int k = 3; k >= 0; k--) begin
         {primaryLoopModeBitHigh, primaryLoopModeBitLow} = 2'(k);
         cyc(6);
         chk("pin mode", 8'(k), primaryLoopMode);
      end
      i_dcs_host_model.xfer({1'b0, OFS_MODE_SELECT[6:0], 8'h5e}, rx);
      wrModel.push_back(8'h5e);
      chk("reg mode", 8'h02, primaryLoopMode);
      i_dcs_host_model.xfer({1'b1, OFS_MODE_SELECT[6:0], 8'h00}, rx);
      chk("reg read", wrModel.pop_front(), rx);
      i_dcs_host_model.xfer({1'b0, OFS_CONTROL[6:0], 8'h05}, rx);
      wrModel.push_back(8'h05);
      i_dcs_host_model.xfer({1'b1, OFS_CONTROL[6:0], 8'h00}, rx);
      chk("control", wrModel.pop_front(), rx);
      i_dcs_host_model.xfer(16'hc000, rx);
      chk("unmapped", UNMAPPED_READ, rx);
      for (int i = 0; i < 80; i++) begin
         lfsr = nxt(lfsr);
         if (hitlessSwitchStrap && !lfsr[3]) expPulse++;
         {hitlessSwitchStrap, roleSelectPin, differentialOutZeroEnable, differentialOutOneEnable} = lfsr[3:0];
         {loopFreqLocked, loopPhaseLocked, loopInHoldover} = lfsr[6:4];
         cyc(5);
         chk("hitless", lfsr[3], hitlessSwitchEnabled);
         chk("slave", lfsr[2], slaveMode);
         chk("diff0", lfsr[1], diffZeroDriverOn);
         chk("diff1", lfsr[0], diffOneDriverOn);
         chk("lock", lfsr[6] & lfsr[5], primaryLoopLocked);
         chk("holdover", lfsr[4], primaryLoopInHoldover);
      end
      i_dcs_host_model.xfer({1'b1, OFS_STATUS[6:0], 8'h00}, rx);
      chk("status", {1'b0, lfsr[0], lfsr[1], lfsr[2], lfsr[3], lfsr[4], lfsr[6] & lfsr[5], 1'b1}, rx);
      chk("realign count", 8'(expPulse), 8'(nPulse));
      twoWirePortStrap = 1'b1;
      selPull = 1'b0;
      cyc(6);
      chk("addr bit", 1'b0, twoWireAddressBitZero);
      selPull = 1'b1;
      i_dcs_host_model.xfer({1'b0, OFS_MODE_SELECT[6:0], 8'h01}, rx);
      chk("ignored", 8'h02, primaryLoopMode);
      chk("so released", 1'b1, serialOutOeN);
      i_dcs_host_model.twiFrame({TWI_ADDR_HIGH, 2'b10, 1'b1, OFS_MODE_SELECT, 1'b1, 8'h03, 2'b10});
      chk("two-wire write", 8'h03, primaryLoopMode);
      i_dcs_host_model.twiFrame({TWI_ADDR_HIGH, 2'b00, 1'b1, OFS_MODE_SELECT, 1'b1, 8'h01, 2'b10});
      chk("wrong address", 8'h03, primaryLoopMode);
      chk("addr bit", 1'b1, twoWireAddressBitZero);
      chk("clk released", 1'b1, sharedClkOeN);
      end_sim();
   end
   initial begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule : dcs_pins_bench
`default_nettype wire
